/* File: rtl/mfs_pkg.sv */
package mfs_pkg;
   // instruction cycle phases, gray ordered
   typedef enum logic [1:0] {
      PH_T1 = 2'b00,
      PH_T2 = 2'b01,
      PH_T3 = 2'b11,
      PH_T4 = 2'b10
   } mfs_phase_e;

   // sequencer core widths
   localparam int PC_WIDTH = 10;
   localparam int PAGE_WIDTH = 2;
   localparam int WORD_WIDTH = 16;
   localparam int DATA_WIDTH = 8;
   localparam int STACK_DEPTH = 4;

   // values after reset
   localparam logic [9:0] RESET_VECTOR = 10'h000;
   localparam logic [2:0] STACK_PTR_RESET = 3'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;

   // status field positions
   localparam int ST_CARRY = 0;
   localparam int ST_ZERO = 1;
   localparam int ST_AUXC = 2;
   localparam int ST_OVF = 3;

   // alu operation codes presented by the decoder
   typedef enum logic [4:0] {
      OP_NONE = 5'h00,
      OP_ADD = 5'h01,
      OP_ADC = 5'h02,
      OP_SUB = 5'h03,
      OP_SBC = 5'h04,
      OP_DECADJ = 5'h05,
      OP_AND = 5'h06,
      OP_OR = 5'h07,
      OP_XOR = 5'h08,
      OP_CPL = 5'h09,
      OP_RR = 5'h0A,
      OP_RRC = 5'h0B,
      OP_RL = 5'h0C,
      OP_RLC = 5'h0D,
      OP_INC = 5'h0E,
      OP_DEC = 5'h0F,
      OP_PASS = 5'h10
   } mfs_aluop_e;

   // flow control kinds presented by the decoder
   typedef enum logic [2:0] {
      FL_SEQ = 3'h0,
      FL_JUMP = 3'h1,
      FL_CALL = 3'h2,
      FL_RETURN = 3'h3,
      FL_SKIP = 3'h4,
      FL_TABLE = 3'h5
   } mfs_flow_e;
endpackage : mfs_pkg

/* File: rtl/mfs_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module mfs_alu
   import mfs_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire mfs_aluop_e op,
   input wire logic [WIDTH-1:0] opA,
   input wire logic [WIDTH-1:0] opB,
   input wire logic carryIn,
   output logic [WIDTH-1:0] result,
   output logic carryOut,
   output logic auxCarry,
   output logic overflow,
   output logic isZero
);
   logic [WIDTH:0] wide;
   logic [4:0] nib;

   // 8-bit datapath; borrow shows as carry clear, as usual for this family
   always_comb begin
      wide = '0;
      nib = '0;
      overflow = 1'b0;
      case (op)
         OP_ADD, OP_ADC: begin
            wide = {1'b0, opA} + {1'b0, opB} + {{WIDTH{1'b0}},
               (op == OP_ADC) & carryIn};
            nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} +
               {4'h0, (op == OP_ADC) & carryIn};
            overflow = (opA[WIDTH-1] == opB[WIDTH-1]) &&
               (wide[WIDTH-1] != opA[WIDTH-1]);
         end
         OP_SUB, OP_SBC: begin
            wide = {1'b0, opA} + {1'b0, ~opB} + {{WIDTH{1'b0}},
               (op == OP_SUB) | carryIn};
            nib = {1'b0, opA[3:0]} + {1'b0, ~opB[3:0]} +
               {4'h0, (op == OP_SUB) | carryIn};
            overflow = (opA[WIDTH-1] != opB[WIDTH-1]) &&
               (wide[WIDTH-1] != opA[WIDTH-1]);
         end
         OP_DECADJ: begin
            // adjust each nibble that passed nine
            wide = {1'b0, opA};
            if (opA[3:0] > 4'h9)
               wide = wide + {{(WIDTH-3){1'b0}}, 4'h6};
            if (wide[WIDTH:4] > {1'b0, 4'h9} || carryIn)
               wide = wide + {1'b0, 8'h60};
            wide[WIDTH] = wide[WIDTH] | carryIn;
         end
         OP_AND: wide = {1'b0, opA & opB};
         OP_OR: wide = {1'b0, opA | opB};
         OP_XOR: wide = {1'b0, opA ^ opB};
         OP_CPL: wide = {1'b0, ~opB};
         OP_RR: wide = {1'b0, opB[0], opB[WIDTH-1:1]};
         OP_RRC: wide = {opB[0], carryIn, opB[WIDTH-1:1]};
         OP_RL: wide = {1'b0, opB[WIDTH-2:0], opB[WIDTH-1]};
         OP_RLC: wide = {opB[WIDTH-1], opB[WIDTH-2:0], carryIn};
         OP_INC: wide = {1'b0, opB} + 9'h001;
         OP_DEC: wide = {1'b0, opB} - 9'h001;
         default: wide = {1'b0, opB};
      endcase
   end

   assign result = wide[WIDTH-1:0];
   assign carryOut = wide[WIDTH];
   assign auxCarry = nib[4];
   assign isZero = (wide[WIDTH-1:0] == '0);
endmodule : mfs_alu
`default_nettype wire

/* File: rtl/mfs_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module mfs_stack
   import mfs_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int WIDTH = 10
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] pushValue,
   output logic [WIDTH-1:0] topValue,
   output logic full
);
   logic [WIDTH-1:0] levels_ff [DEPTH];
   logic [2:0] count_ff;

   // shift stack: a push when full drops the oldest level off the bottom
   always_ff @(posedge clock) begin
      if (push) begin
         levels_ff[0] <= pushValue;
         for (int i = 1; i < DEPTH; i++) begin
            levels_ff[i] <= levels_ff[i-1];
         end
      end else if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            levels_ff[i] <= levels_ff[i+1];
         end
      end
   end

   // level count, the hidden pointer
   always_ff @(posedge clock) begin
      if (srst) begin
         count_ff <= STACK_PTR_RESET;
      end else if (push && count_ff != 3'(DEPTH)) begin
         count_ff <= count_ff + 3'h1;
      end else if (pop && !push && count_ff != 3'h0) begin
         count_ff <= count_ff - 3'h1;
      end
   end

   assign topValue = levels_ff[0];
   assign full = (count_ff == 3'(DEPTH));
endmodule : mfs_stack
`default_nettype wire

/* File: rtl/mfs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: four phases form one instruction cycle
// RL2: first phase advances counter and fetches
// RL3: overlapped fetch; flow changes cost two cycles
// RL4: counter increments unless flow redirects
// RL5: ten bit counter, only low byte visible
// RL6: jumps, calls, interrupts, reset load target
// RL7: taken skip discards prefetch, inserts dummy
// RL8: low byte write jumps within page
// RL9: low byte readable and writable register
// RL10: hidden four level counter stack
// RL11: call or interrupt acknowledge pushes counter
// RL12: returns pop and restore counter
// RL13: reset points stack at top
// RL14: full stack holds interrupt until return
// RL15: call on full stack loses oldest
// RL16: eight bit alu through accumulator
// RL17: result to destination, status updated
// RL18: add, subtract with carry, decimal adjust
// RL19: program memory 1K by 16 words
// RL20: table reads use separate table pointer
// RL21: execution starts at address zero
// RL22: table low to destination, high separate
// RL23: table instructions take two cycles
// RL24: interrupt pushes next instruction address
// RL25: low byte write redirects next fetch
module mfs_sequencer
   import mfs_pkg::*;
#(
   parameter int PCW = PC_WIDTH,
   parameter int DW = DATA_WIDTH,
   parameter int IW = WORD_WIDTH,
   parameter logic [9:0] INT_VECTOR = 10'h004
) (
   input wire logic clock,
   input wire logic srst,
   // program memory side
   output logic [PCW-1:0] progAddr,
   output logic progRead,
   input wire logic [IW-1:0] progData,
   // decoder side: describes the instruction now executing
   output logic [IW-1:0] instrWord,
   output logic instrValid,
   input wire mfs_flow_e flowKind,
   input wire logic [PCW-1:0] flowTarget,
   input wire mfs_aluop_e aluOp,
   input wire logic [DW-1:0] memOperand,
   input wire logic useImmediate,
   input wire logic destIsAcc,
   input wire logic skipOnZero,
   input wire logic [PCW-1:0] tablePointer,
   // low byte register port
   input wire logic pcLowWrite,
   input wire logic [DW-1:0] pcLowWriteData,
   output logic [DW-1:0] pcLowReadData,
   // interrupt side
   input wire logic intRequest,
   output logic intAck,
   // results
   output logic [DW-1:0] accumulator,
   output logic [DW-1:0] memResult,
   output logic memWrite,
   output logic [DW-1:0] tableHighResult,
   output logic [3:0] status,
   output mfs_phase_e cyclePhases
);
   ////////////////////////////////////////////////////////////////////
   mfs_phase_e phase_ff;
   logic [PCW-1:0] pc_ff;
   logic [PCW-1:0] nxt_pc;
   logic [IW-1:0] instr_ff;
   logic valid_ff;
   logic dummy_ff;
   logic tableFetch_ff;
   logic pending_ff;
   logic [DW-1:0] acc_ff;
   logic [3:0] status_ff;
   logic [DW-1:0] memRes_ff;
   logic memWr_ff;
   logic [DW-1:0] tblHigh_ff;
   logic [DW-1:0] pcLowPending_ff;
   logic pcLowWritten_ff;
   logic [PCW-1:0] stackTop;
   logic stackFull;
   logic push;
   logic pop;
   logic [PCW-1:0] pushValue;
   logic [DW-1:0] aluB;
   logic [DW-1:0] aluResult;
   logic aluCarry;
   logic aluAux;
   logic aluOvf;
   logic aluZero;
   logic atT1;
   logic atT4;
   logic execNow;
   logic takeInt;
   logic skipTaken;
   logic isTable;
   logic intWindow;
   logic tableSlot;

   assign atT1 = (phase_ff == PH_T1);
   assign atT4 = (phase_ff == PH_T4);
   // an instruction completes at the end of its T4 unless dummy
   assign execNow = atT4 && valid_ff && !dummy_ff;
   // the slot after a table instruction reads table data, not code
   assign tableSlot = dummy_ff && tableFetch_ff;

   ////////////////////////////////////////////////////////////////////
   // phase generator: one gray step per system clock
   // gray order keeps a decode of one phase from glitching into another
   always_ff @(posedge clock) begin
      if (srst) begin
         phase_ff <= PH_T1;
      end else begin
         case (phase_ff) // RL1
            PH_T1: phase_ff <= PH_T2;
            PH_T2: phase_ff <= PH_T3;
            PH_T3: phase_ff <= PH_T4;
            default: phase_ff <= PH_T1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // an interrupt may cut in only where the counter already holds the
   // true next address: a dummy slot or a plain sequential step; a
   // branch, skip, table or low byte write in flight would lose its target
   assign intWindow = atT4 && !pcLowWritten_ff &&
      !(execNow && flowKind != FL_SEQ); // RL24
   // acknowledge waits while every stack level is taken
   assign takeInt = intWindow && (pending_ff || intRequest) &&
      !stackFull; // RL14
   assign skipTaken = execNow && flowKind == FL_SKIP &&
      (aluZero == skipOnZero);
   assign isTable = execNow && flowKind == FL_TABLE;

   // request flag stays recorded until acknowledged; a request served in
   // the very cycle it arrives is not kept as well, or it would be
   // serviced twice, while one arriving behind an older recorded
   // request is kept
   always_ff @(posedge clock) begin
      if (srst) begin
         pending_ff <= 1'b0;
      end else if (takeInt) begin
         pending_ff <= pending_ff && intRequest;
      end else if (intRequest) begin
         pending_ff <= 1'b1;
      end
   end

   assign intAck = takeInt;

   ////////////////////////////////////////////////////////////////////
   // push and pop requests to the hidden stack
   always_comb begin
      push = 1'b0;
      pop = 1'b0;
      pushValue = pc_ff;
      if (takeInt) begin
         push = 1'b1; // RL11
         pushValue = pc_ff; // RL24
      end else if (execNow && flowKind == FL_CALL) begin
         push = 1'b1; // RL15
      end else if (execNow && flowKind == FL_RETURN) begin
         pop = 1'b1; // RL12
      end
   end

   // a call on a full stack still pushes; the oldest address falls off
   mfs_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PCW)
   ) u_stack (
      .clock(clock),
      .srst(srst), // RL13
      .push(push),
      .pop(pop),
      .pushValue(pushValue),
      .topValue(stackTop),
      .full(stackFull)
   ); // RL10

   ////////////////////////////////////////////////////////////////////
   // next fetch address, chosen at T4 for the coming T1
   always_comb begin
      nxt_pc = pc_ff + PCW'(1); // RL4
      if (takeInt) begin
         nxt_pc = INT_VECTOR; // RL6
      end else if (pcLowWritten_ff) begin
         nxt_pc = {pc_ff[PCW-1:DW], pcLowPending_ff}; // RL8 RL25
      end else if (execNow) begin
         case (flowKind)
            FL_JUMP, FL_CALL: nxt_pc = flowTarget; // RL6
            FL_RETURN: nxt_pc = stackTop; // RL12
            FL_TABLE: nxt_pc = pc_ff; // RL23
            default: nxt_pc = pc_ff + PCW'(1);
         endcase
      end else if (tableSlot) begin
         // the word after the table instruction is already held, so
         // fetching carries on past it and the table costs two cycles
         nxt_pc = pc_ff + PCW'(1); // RL23
      end
   end

   // counter moves only as T1 starts; reset lands on the vector
   // a single load point keeps every redirect in step with the phases
   always_ff @(posedge clock) begin
      if (srst) begin
         pc_ff <= RESET_VECTOR; // RL21
      end else if (atT4) begin
         pc_ff <= nxt_pc; // RL2
      end
   end

   ////////////////////////////////////////////////////////////////////
   // low byte write is latched and acted on at the next boundary
   // the page bits are not reachable and keep their value
   always_ff @(posedge clock) begin
      if (srst) begin
         pcLowWritten_ff <= 1'b0;
         pcLowPending_ff <= '0;
      end else if (pcLowWrite) begin
         pcLowWritten_ff <= 1'b1; // RL9
         pcLowPending_ff <= pcLowWriteData;
      end else if (atT4) begin
         pcLowWritten_ff <= 1'b0;
      end
   end

   assign pcLowReadData = pc_ff[DW-1:0]; // RL5 RL9

   ////////////////////////////////////////////////////////////////////
   // fetch: prefetched word is held; flow changes mark a dummy slot
   // trading one lost cycle for no branch predictor
   always_ff @(posedge clock) begin
      if (srst) begin
         instr_ff <= '0;
         valid_ff <= 1'b0;
         dummy_ff <= 1'b0;
         tableFetch_ff <= 1'b0;
      end else if (atT4) begin
         // the table slot returns data, so the prefetched word is kept
         if (!tableSlot) begin
            instr_ff <= progData; // RL19
         end
         valid_ff <= 1'b1;
         dummy_ff <= takeInt || pcLowWritten_ff || skipTaken || // RL7
            (execNow && (flowKind == FL_JUMP || flowKind == FL_CALL ||
            flowKind == FL_RETURN || flowKind == FL_TABLE)); // RL3
         tableFetch_ff <= isTable;
      end
   end

   // table slot presents the table pointer instead of the counter
   assign progAddr = tableSlot ? tablePointer : pc_ff; // RL20
   assign progRead = atT1 || (atT4 && tableFetch_ff); // RL20
   assign instrWord = instr_ff;
   assign instrValid = valid_ff && !dummy_ff;

   ////////////////////////////////////////////////////////////////////
   // operand b: the immediate field of the word, or the memory operand
   assign aluB = useImmediate ? instr_ff[DW-1:0] : memOperand;

   mfs_alu #(
      .WIDTH(DW)
   ) u_alu (
      .op(aluOp),
      .opA(acc_ff),
      .opB(aluB),
      .carryIn(status_ff[ST_CARRY]),
      .result(aluResult),
      .carryOut(aluCarry),
      .auxCarry(aluAux),
      .overflow(aluOvf),
      .isZero(aluZero)
   ); // RL16 RL18

   // result lands in accumulator or memory at end of execution
   // the table slot hands its low byte out through the same write path
   always_ff @(posedge clock) begin
      if (srst) begin
         acc_ff <= ACC_RESET;
         memRes_ff <= '0;
         memWr_ff <= 1'b0;
      end else begin
         memWr_ff <= 1'b0;
         if (execNow && aluOp != OP_NONE && flowKind == FL_SEQ) begin
            if (destIsAcc) begin
               acc_ff <= aluResult; // RL17
            end else begin
               memRes_ff <= aluResult;
               memWr_ff <= 1'b1;
            end
         end else if (execNow && flowKind == FL_SKIP && !destIsAcc &&
            aluOp != OP_NONE) begin
            memRes_ff <= aluResult; // skip-with-update forms
            memWr_ff <= 1'b1;
         end else if (dummy_ff && tableFetch_ff && atT4) begin
            memRes_ff <= progData[DW-1:0]; // RL22
            memWr_ff <= 1'b1;
         end
      end
   end

   // status flags; logic ops leave carry alone
   // a borrow reads as carry clear after a subtract
   always_ff @(posedge clock) begin
      if (srst) begin
         status_ff <= '0;
      end else if (execNow && aluOp != OP_NONE && aluOp != OP_PASS) begin
         status_ff[ST_ZERO] <= aluZero; // RL17
         if (aluOp inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC}) begin
            status_ff[ST_CARRY] <= aluCarry;
            status_ff[ST_AUXC] <= aluAux;
            status_ff[ST_OVF] <= aluOvf;
         end else if (aluOp inside {OP_DECADJ, OP_RRC, OP_RLC}) begin
            status_ff[ST_CARRY] <= aluCarry;
         end
      end
   end

   // high part of the table word; bits above the word read zero
   always_ff @(posedge clock) begin
      if (srst) begin
         tblHigh_ff <= '0;
      end else if (dummy_ff && tableFetch_ff && atT4) begin
         tblHigh_ff <= DW'(progData[IW-1:DW]); // RL22
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from the registers
   assign accumulator = acc_ff;
   assign memResult = memRes_ff;
   assign memWrite = memWr_ff;
   assign tableHighResult = tblHigh_ff;
   assign status = status_ff;
   assign cyclePhases = phase_ff;
endmodule : mfs_sequencer
`default_nettype wire

/* File: dv/mfs_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module mfs_prog_mem
   import mfs_pkg::*;
(
   input wire logic [PC_WIDTH-1:0] progAddr,
   output logic [WORD_WIDTH-1:0] progData
);
   // 1K words of 16 bits, loaded by the bench before reset ends
   logic [WORD_WIDTH-1:0] words [0:1023];
   // async read: fetch and table slots share the address path
   assign progData = words[progAddr];
endmodule : mfs_prog_mem
`default_nettype wire

/* File: dv/mfs_sequencer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mfs_sequencer_assertions
   import mfs_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [9:0] progAddr,
   input wire logic progRead,
   input wire logic instrValid,
   input wire logic intAck,
   input wire logic [7:0] pcLowReadData,
   input wire logic [7:0] accumulator,
   input wire logic memWrite,
   input wire logic [7:0] tableHighResult,
   input wire mfs_phase_e cyclePhases
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   // phases and fetch
   phase_order_a: assert property (cyclePhases == PH_T4 |=>
      cyclePhases == PH_T1 ##1 cyclePhases == PH_T2 ##1
      cyclePhases == PH_T3 ##1 cyclePhases == PH_T4)
      else $error("phase order broken");
   fetch_in_t1_a: assert property (cyclePhases == PH_T1 |-> progRead)
      else $error("no fetch in first phase");
   reset_vector_a: assert property ($fell(srst) |->
      progAddr == RESET_VECTOR && cyclePhases == PH_T1)
      else $error("start not at vector zero");
   ////////////////////////////////////////////////////////////////////////
   // state moves only on the instruction boundary
   pc_low_stable_a: assert property (cyclePhases != PH_T4 |=>
      $stable(pcLowReadData))
      else $error("low byte moved mid cycle");
   acc_stable_a: assert property (cyclePhases != PH_T4 |=>
      $stable(accumulator))
      else $error("accumulator moved mid cycle");
   tbl_stable_a: assert property (cyclePhases != PH_T4 |=>
      $stable(tableHighResult))
      else $error("table high moved mid cycle");
   mem_pulse_a: assert property (memWrite |->
      cyclePhases == PH_T1 ##1 !memWrite)
      else $error("memory write not a single pulse");
   ack_in_t4_a: assert property (intAck |-> cyclePhases == PH_T4)
      else $error("acknowledge outside last phase");
   ////////////////////////////////////////////////////////////////////////
   // main scenarios
   ack_c: cover property (intAck);
   dummy_c: cover property (cyclePhases == PH_T4 && !instrValid);
   restart_c: cover property ($fell(srst));
endmodule : mfs_sequencer_assertions
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import mfs_pkg::*;
;
   logic clock, srst, progRead, instrValid, pcLowWrite, intRequest;
   logic useImm, destIsAcc, skipOnZero, intAck, memWrite, hit, opOk;
   logic [9:0] progAddr, flowTarget, tablePtr;
   logic [15:0] progData, instrWord;
   logic [7:0] memOperand, pcLowWd, pcLowRd, acc, memResult, tblHigh;
   logic [3:0] status;
   mfs_flow_e flowKind;
   mfs_aluop_e aluOp;
   mfs_phase_e cyclePhases;
   int compares, miscompares, cycles, n;
   // interrupt entry, the design's default vector
   localparam logic [9:0] INT_VECTOR_T = 10'h004;
   ////////////////////////////////////////////////////////////////////////
   mfs_sequencer dut (
      .clock(clock),
      .srst(srst),
      .progAddr(progAddr),
      .progRead(progRead),
      .progData(progData),
      .instrWord(instrWord),
      .instrValid(instrValid),
      .flowKind(flowKind),
      .flowTarget(flowTarget),
      .aluOp(aluOp),
      .memOperand(memOperand),
      .useImmediate(useImm),
      .destIsAcc(destIsAcc),
      .skipOnZero(skipOnZero),
      .tablePointer(tablePtr),
      .pcLowWrite(pcLowWrite),
      .pcLowWriteData(pcLowWd),
      .pcLowReadData(pcLowRd),
      .intRequest(intRequest),
      .intAck(intAck),
      .accumulator(acc),
      .memResult(memResult),
      .memWrite(memWrite),
      .tableHighResult(tblHigh),
      .status(status),
      .cyclePhases(cyclePhases)
   );
   mfs_prog_mem mem (
      .progAddr(progAddr),
      .progData(progData)
   );
   ////////////////////////////////////////////////////////////////////////
   // decoder model: word = kind[15:13], op[12:8], imm or target below
   assign opOk = instrValid && (instrWord[15:13] == 3'h0 ||
      instrWord[15:13] == 3'h4);
   // registered a cycle late; still well before the sampling edge
   always @(posedge clock) begin
      flowKind <= instrValid ? mfs_flow_e'(instrWord[15:13]) : FL_SEQ;
      aluOp <= opOk ? mfs_aluop_e'(instrWord[12:8]) : OP_NONE;
      flowTarget <= instrWord[9:0];
      destIsAcc <= instrWord[15:13] != 3'h4;
   end
   // timeout: the whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] w(input logic [2:0] k,
      input logic [12:0] v);
      return {k, v};
   endfunction : w
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check
   // counts falling edges until address a is fetched in the first phase
   task automatic waitFetch(input logic [9:0] a, input int lim);
      n = 0;
      hit = 1'b0;
      while (!hit && n < lim) begin
         @(negedge clock);
         n++;
         hit = progRead === 1'b1 && cyclePhases === PH_T1 &&
            progAddr === a;
      end
   endtask : waitFetch
   task automatic doReset(input int len);
      @(posedge clock);
      srst <= 1'b1;
      repeat (len) @(posedge clock);
      srst <= 1'b0;
   endtask : doReset
   task automatic complete_run();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {srst, pcLowWrite, intRequest, pcLowWd} = '0;
      {compares, miscompares, cycles} = '0;
      {memOperand, useImm, skipOnZero, tablePtr} = {8'h00, 2'b11, 10'h306};
      for (int i = 0; i < 1024; i++) mem.words[i] = 16'h0000;
      mem.words[0] = w(FL_SEQ, {OP_ADD, 8'h05});
      mem.words[1] = w(FL_JUMP, 13'h0010);
      mem.words[2] = w(FL_SEQ, {OP_ADD, 8'h80});
      mem.words[16] = w(FL_SEQ, {OP_ADD, 8'h03});
      mem.words[17] = w(FL_SKIP, {OP_AND, 8'h00});
      mem.words[18] = w(FL_SEQ, {OP_ADD, 8'h40});
      mem.words[19] = w(FL_SEQ, {OP_ADD, 8'h01});
      mem.words[20] = w(FL_CALL, 13'h0020);
      mem.words[21] = w(FL_SEQ, {OP_ADD, 8'h02});
      mem.words[22] = w(FL_TABLE, 13'h0000);
      mem.words[23] = w(FL_JUMP, 13'h0117);
      mem.words[32] = w(FL_SEQ, {OP_ADD, 8'h10});
      mem.words[33] = w(FL_RETURN, 13'h0000);
      mem.words[4] = w(FL_RETURN, 13'h0000);
      mem.words[279] = w(FL_JUMP, 13'h0117);
      mem.words[280] = w(FL_JUMP, 13'h0117);
      mem.words[304] = w(FL_JUMP, 13'h0130);
      mem.words[774] = 16'hA55A;
      doReset(16);
      // program flow: jump, taken skip, call, return, table read
      waitFetch(10'h000, 2);
      check({15'h0, hit}, 16'h0001);
      waitFetch(10'h001, 8);
      check(instrWord, mem.words[0]);
      waitFetch(10'h010, 20);
      check(16'(n), 16'h0008);
      waitFetch(10'h013, 20);
      check({12'h000, status}, 16'h0001 << ST_ZERO);
      check({8'h00, acc}, 16'h0008);
      waitFetch(10'h117, 300);
      check({15'h0, hit}, 16'h0001);
      check({8'h00, acc}, 16'h001B);
      check({8'h00, memResult}, 16'h005A);
      check({8'h00, tblHigh}, 16'h00A5);
      $display("flow test done");
      // interrupt enters the vector and returns to the loop
      @(posedge clock) intRequest <= 1'b1;
      @(posedge clock) intRequest <= 1'b0;
      waitFetch(INT_VECTOR_T, 40);
      check({15'h0, hit}, 16'h0001);
      waitFetch(10'h117, 40);
      check({15'h0, hit}, 16'h0001);
      $display("interrupt test done");
      // low byte write jumps inside the current page
      @(posedge clock) pcLowWrite <= 1'b1;
      pcLowWd <= 8'h30;
      @(posedge clock) pcLowWrite <= 1'b0;
      waitFetch(10'h130, 40);
      check({15'h0, hit}, 16'h0001);
      check({8'h00, pcLowRd}, 16'h0030);
      $display("low byte test done");
      // reset in mid run restarts at zero with a clear accumulator
      doReset(2);
      waitFetch(10'h000, 2);
      check({15'h0, hit}, 16'h0001);
      check({8'h00, acc}, 16'h0000);
      $display("restart test done");
      complete_run();
   end
endmodule : tb
bind mfs_sequencer mfs_sequencer_assertions chk (
   .clock(clock),
   .srst(srst),
   .progAddr(progAddr),
   .progRead(progRead),
   .instrValid(instrValid),
   .intAck(intAck),
   .pcLowReadData(pcLowReadData),
   .accumulator(accumulator),
   .memWrite(memWrite),
   .tableHighResult(tableHighResult),
   .cyclePhases(cyclePhases)
);
`default_nettype wire
